// ===== logic/acr_pkg.sv
// Shared constants for the alert configuration register bank
package acr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_AUX_HOT_EN = 8'h1d;
    localparam logic [7:0] IDX_CAL_FORCE = 8'h1e;
    localparam logic [7:0] IDX_CELL_CLR = 8'h1f;
    localparam logic [7:0] IDX_CELL_SET = 8'h20;
    localparam logic [7:0] IDX_AUX_CFG = 8'h30;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h31;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h32;
    localparam logic [7:0] IDX_CELL_ALERTS = 8'h33;
    localparam logic [7:0] IDX_AUX_CAL_ALERTS = 8'h34;
    // Field positions
    localparam int THR_LSB = 2;
    localparam int AUX_CFG_GPIO_LSB = 8;
    localparam int ALERTS_CAL_LSB = 8;
    localparam int CAL_ADC_OFS = 4;
    localparam int CAL_RAMP_OFS = 3;
    localparam int CAL_RATIO_OFS = 2;
    localparam int CAL_PYR_GAIN = 1;
    localparam int CAL_RAMP_GAIN = 0;
    localparam int IRQ_CELL = 0;
    localparam int IRQ_AUX = 1;
    localparam int IRQ_CAL = 2;
    // Widths and reset values
    localparam int THR_W = 14;
    localparam int NUM_CAL = 5;
    localparam int NUM_IRQ = 3;
    localparam logic [5:0] RST_AUX_HOT_EN = 6'h0;
    localparam logic [4:0] RST_CAL_FORCE = 5'h00;
    localparam logic [13:0] RST_CELL_CLR = 14'h3fff;
    localparam logic [13:0] RST_CELL_SET = 14'h3fff;
    // Bus engine states, Gray coded along idle-wait-data
    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_RWAIT = 2'b01,
        ACR_RDATA = 2'b11,
        ACR_WDATA = 2'b10
    } acr_bus_st_t;
endpackage : acr_pkg

// ===== logic/acr_cell_hyst.sv
// One cell's overvoltage alert with set and clear hysteresis
`timescale 1ns/1ns
module acr_cell_hyst
    import acr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic upd,
    input wire logic [THR_W-1:0] code,
    input wire logic [THR_W-1:0] set_level,
    input wire logic [THR_W-1:0] clr_level,
    output logic alert_q
);
    logic alert_d;

    // Set wins if software leaves clear above set
    always_comb begin
        alert_d = alert_q;
        if (upd) begin
            if (code > set_level) begin
                alert_d = 1'b1;
            end else if (code <= clr_level) begin
                alert_d = 1'b0;
            end
        end
    end

    // Between the levels the alert keeps its state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_CELL_SET: assert property (upd && code > set_level |=> alert_q)
        else $error("Cell alert not set above set level");
    AST_CELL_CLR: assert property (
        upd && code <= clr_level && code <= set_level |=> !alert_q)
        else $error("Cell alert not cleared at clear level");
    AST_CELL_HOLD: assert property (!upd |=> $stable(alert_q))
        else $error("Cell alert moved without a measurement");
endmodule : acr_cell_hyst

// ===== logic/acr_regs.sv
// Alert configuration register bank with AHB-Lite slave
`timescale 1ns/1ns
module acr_regs
    import acr_pkg::*;
#(
    parameter int NUM_CELLS = 14,
    parameter int NUM_AUX = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cell_meas_valid,
    input wire logic cell_meas_unipolar,
    input wire logic [3:0] cell_meas_index,
    input wire logic [THR_W-1:0] cell_meas_code,
    input wire logic aux_meas_valid,
    input wire logic [2:0] aux_meas_chan,
    input wire logic [THR_W-1:0] aux_meas_code,
    input wire logic [THR_W-1:0] aux_ratio_hot_set_level,
    input wire logic [THR_W-1:0] aux_abs_hot_set_level,
    input wire logic comp_aux_valid,
    input wire logic [NUM_AUX-1:0] comp_aux_below,
    input wire logic [NUM_CAL-1:0] cal_range_fail,
    input wire logic [NUM_CAL-1:0] cal_alert_mask,
    output logic [NUM_CELLS-1:0] cell_high_voltage_alert,
    output logic [NUM_AUX-1:0] aux_hot_alert,
    output logic [NUM_AUX-1:0] aux_reference_select,
    output logic [NUM_AUX-1:0] aux_pin_gpio_mode,
    output logic adc_offset_cal_alert,
    output logic ramp_offset_cal_alert,
    output logic ratio_offset_cal_alert,
    output logic pyramid_gain_cal_alert,
    output logic ramp_gain_cal_alert,
    output logic irq
);
    // Fields of the config register must not overlap
    if (NUM_CELLS < 1 || NUM_CELLS > 16 ||
        NUM_AUX < 1 || NUM_AUX > 8) begin : g_bad_params
        $error("acr_regs: channel counts out of range");
    end

    acr_bus_st_t st_q, st_d;
    logic [7:0] idx_q, idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [NUM_AUX-1:0] aux_hot_en_q, aux_hot_en_d;
    logic [NUM_AUX-1:0] ref_sel_q, ref_sel_d;
    logic [NUM_AUX-1:0] gpio_q, gpio_d;
    logic [NUM_AUX-1:0] aux_alert_q, aux_alert_d;
    logic [NUM_CAL-1:0] cal_force_q, cal_force_d;
    logic [NUM_CAL-1:0] cal_alert_q, cal_alert_d;
    logic [THR_W-1:0] cell_clr_q, cell_clr_d;
    logic [THR_W-1:0] cell_set_q, cell_set_d;
    logic [NUM_IRQ-1:0] irq_stat_q, irq_stat_d;
    logic [NUM_IRQ-1:0] irq_mask_q, irq_mask_d;
    logic [NUM_CELLS-1:0] cell_prev_q;
    logic [NUM_CELLS-1:0] cell_alert;
    logic accept;
    logic wr_commit;
    logic [NUM_IRQ-1:0] irq_evt;
    logic [THR_W-1:0] aux_level;

    // Only the address phase of a valid transfer is taken
    assign accept = hsel && htrans[1] && hready;
    assign wr_commit = (st_q == ACR_WDATA);
    // Reads take one wait state so a preceding write lands first
    assign hreadyout = (st_q != ACR_RWAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Bus engine next state and read data capture
    always_comb begin
        st_d = ACR_IDLE;
        idx_d = idx_q;
        hrdata_d = hrdata_q;
        if (st_q == ACR_RWAIT) begin
            st_d = ACR_RDATA;
            hrdata_d = 32'h0000_0000;
            case (idx_q)
                IDX_AUX_HOT_EN: begin
                    hrdata_d[NUM_AUX-1:0] = aux_hot_en_q;
                end
                IDX_CAL_FORCE: begin
                    hrdata_d[NUM_CAL-1:0] = cal_force_q;
                end
                IDX_CELL_CLR: begin
                    hrdata_d[THR_LSB +: THR_W] = cell_clr_q;
                end
                IDX_CELL_SET: begin
                    hrdata_d[THR_LSB +: THR_W] = cell_set_q;
                end
                IDX_AUX_CFG: begin
                    hrdata_d[NUM_AUX-1:0] = ref_sel_q;
                    hrdata_d[AUX_CFG_GPIO_LSB +: NUM_AUX] = gpio_q;
                end
                IDX_IRQ_STAT: begin
                    hrdata_d[NUM_IRQ-1:0] = irq_stat_q;
                end
                IDX_IRQ_MASK: begin
                    hrdata_d[NUM_IRQ-1:0] = irq_mask_q;
                end
                IDX_CELL_ALERTS: begin
                    hrdata_d[NUM_CELLS-1:0] = cell_alert;
                end
                IDX_AUX_CAL_ALERTS: begin
                    hrdata_d[NUM_AUX-1:0] = aux_alert_q;
                    hrdata_d[ALERTS_CAL_LSB +: NUM_CAL] = cal_alert_q;
                end
                default: begin
                    hrdata_d = 32'h0000_0000; // Unmapped reads zero
                end
            endcase
        end else if (accept) begin
            idx_d = haddr[9:2];
            st_d = hwrite ? ACR_WDATA : ACR_RWAIT;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ACR_IDLE;
            idx_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            hrdata_q <= hrdata_d;
        end
    end

    // Threshold for the measured aux channel follows its reference choice
    assign aux_level = ref_sel_q[aux_meas_chan] ? aux_ratio_hot_set_level
                                                : aux_abs_hot_set_level;

    // Register writes, aux and calibration alerts, interrupt status
    always_comb begin
        aux_hot_en_d = aux_hot_en_q;
        ref_sel_d = ref_sel_q;
        gpio_d = gpio_q;
        cal_force_d = cal_force_q;
        cell_clr_d = cell_clr_q;
        cell_set_d = cell_set_q;
        irq_mask_d = irq_mask_q;
        aux_alert_d = aux_alert_q;
        irq_stat_d = irq_stat_q;
        // Skipped channels keep their old alert
        for (int i = 0; i < NUM_AUX; i++) begin
            if (aux_hot_en_q[i] && !gpio_q[i]) begin
                if (aux_meas_valid && aux_meas_chan == 3'(i)) begin
                    aux_alert_d[i] = aux_meas_code < aux_level;
                end
                if (comp_aux_valid) begin
                    aux_alert_d[i] = comp_aux_below[i];
                end
            end
        end
        if (wr_commit) begin
            case (idx_q)
                IDX_AUX_HOT_EN: begin
                    aux_hot_en_d = hwdata[NUM_AUX-1:0];
                end
                IDX_CAL_FORCE: begin
                    cal_force_d = hwdata[NUM_CAL-1:0];
                end
                IDX_CELL_CLR: begin
                    cell_clr_d = hwdata[THR_LSB +: THR_W];
                end
                IDX_CELL_SET: begin
                    cell_set_d = hwdata[THR_LSB +: THR_W];
                end
                IDX_AUX_CFG: begin
                    ref_sel_d = hwdata[NUM_AUX-1:0];
                    gpio_d = hwdata[AUX_CFG_GPIO_LSB +: NUM_AUX];
                end
                IDX_IRQ_STAT: begin
                    irq_stat_d = irq_stat_q & ~hwdata[NUM_IRQ-1:0];
                end
                IDX_IRQ_MASK: begin
                    irq_mask_d = hwdata[NUM_IRQ-1:0];
                end
                default: begin
                    irq_mask_d = irq_mask_q; // Unmapped writes dropped
                end
            endcase
        end
        // A disabled channel cannot hold an alert
        aux_alert_d = aux_alert_d & aux_hot_en_d;
        // Force overrides the range check only while unmasked
        cal_alert_d = (cal_force_q | cal_range_fail) & ~cal_alert_mask;
        irq_evt[IRQ_CELL] = |(cell_alert & ~cell_prev_q);
        irq_evt[IRQ_AUX] = |(aux_alert_d & ~aux_alert_q);
        irq_evt[IRQ_CAL] = |(cal_alert_d & ~cal_alert_q);
        // New events win over a write-one clear in the same cycle
        irq_stat_d = irq_stat_d | irq_evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_hot_en_q <= NUM_AUX'(RST_AUX_HOT_EN);
            ref_sel_q <= '0;
            gpio_q <= '0;
            cal_force_q <= RST_CAL_FORCE;
            cell_clr_q <= RST_CELL_CLR;
            cell_set_q <= RST_CELL_SET;
            irq_mask_q <= '0;
            aux_alert_q <= '0;
            cal_alert_q <= '0;
            irq_stat_q <= '0;
            cell_prev_q <= '0;
        end else begin
            aux_hot_en_q <= aux_hot_en_d;
            ref_sel_q <= ref_sel_d;
            gpio_q <= gpio_d;
            cal_force_q <= cal_force_d;
            cell_clr_q <= cell_clr_d;
            cell_set_q <= cell_set_d;
            irq_mask_q <= irq_mask_d;
            aux_alert_q <= aux_alert_d;
            cal_alert_q <= cal_alert_d;
            irq_stat_q <= irq_stat_d;
            cell_prev_q <= cell_alert;
        end
    end

    // One hysteresis tracker per cell; bipolar results are ignored
    for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
        acr_cell_hyst u_hyst (
            .hclk(hclk),
            .hresetn(hresetn),
            .upd(cell_meas_valid && cell_meas_unipolar &&
                 cell_meas_index == 4'(c)),
            .code(cell_meas_code),
            .set_level(cell_set_q),
            .clr_level(cell_clr_q),
            .alert_q(cell_alert[c])
        );
    end

    // Outputs, all from flops
    assign cell_high_voltage_alert = cell_alert;
    assign aux_hot_alert = aux_alert_q;
    assign aux_reference_select = ref_sel_q;
    assign aux_pin_gpio_mode = gpio_q;
    assign adc_offset_cal_alert = cal_alert_q[CAL_ADC_OFS];
    assign ramp_offset_cal_alert = cal_alert_q[CAL_RAMP_OFS];
    assign ratio_offset_cal_alert = cal_alert_q[CAL_RATIO_OFS];
    assign pyramid_gain_cal_alert = cal_alert_q[CAL_PYR_GAIN];
    assign ramp_gain_cal_alert = cal_alert_q[CAL_RAMP_GAIN];
    assign irq = |(irq_stat_q & irq_mask_q);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_READ_WAIT: assert property (accept && !hwrite |=> s_read_wait)
        else $error("Read did not answer after one wait state");
    AST_AUX_CLR: assert property ((aux_alert_q & ~aux_hot_en_q) == '0)
        else $error("Alert held on disabled aux channel");
    // Per channel, so a single GPIO pin is enough to exercise it
    AST_GPIO_SKIP: assert property (
        !wr_commit |=>
        ((aux_alert_q ^ $past(aux_alert_q)) & $past(gpio_q)) == '0)
        else $error("Aux check ran in GPIO mode");
    AST_EN_HOLD: assert property (
        !(wr_commit && idx_q == IDX_AUX_HOT_EN) |=> $stable(aux_hot_en_q))
        else $error("Aux enable changed without a write");
    AST_RESET_VAL: assert property (
        $rose(hresetn) |-> aux_hot_en_q == '0 && cal_force_q == '0 &&
        cell_clr_q == RST_CELL_CLR)
        else $error("Bad reset value");
    AST_CAL_FORCE: assert property (
        (cal_force_q & ~cal_alert_mask) != '0 |=> cal_alert_q != '0)
        else $error("Forced calibration alert missing");
    AST_CAL_MAP: assert property (
        cal_force_q[CAL_ADC_OFS] && !cal_alert_mask[CAL_ADC_OFS]
        |=> adc_offset_cal_alert)
        else $error("Force bit mapped to wrong alert");
    AST_CAL_HOLD: assert property (
        !(wr_commit && idx_q == IDX_CAL_FORCE) |=> $stable(cal_force_q))
        else $error("Force bits changed without a write");
endmodule : acr_regs

// ===== test/acr_regs_tb_top.sv
// Self-checking bench for the alert configuration register bank
`timescale 1ns/1ns
module acr_regs_tb_top;
    import acr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, rd;
    logic cmv = 1'b0, cuni = 1'b0, amv = 1'b0, cpv = 1'b0;
    logic [3:0] cidx = 4'h0;
    logic [2:0] achan = 3'h0;
    logic [13:0] ccode = 14'h0000, acode = 14'h0000;
    logic [5:0] below = 6'h00;
    logic [4:0] fail = 5'h00, cmask = 5'h00, calv;
    logic [13:0] cell_al;
    logic [5:0] aux_al, refsel, gpio;
    logic a_c, r_o, t_o, p_g, r_g;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    // Calibration alerts gathered in force-register bit order
    assign calv = {a_c, r_o, t_o, p_g, r_g};

    // Slave's ready feeds back as the bus ready, single slave
    acr_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cell_meas_valid(cmv), .cell_meas_unipolar(cuni),
        .cell_meas_index(cidx), .cell_meas_code(ccode),
        .aux_meas_valid(amv), .aux_meas_chan(achan),
        .aux_meas_code(acode), .aux_ratio_hot_set_level(14'h0200),
        .aux_abs_hot_set_level(14'h0100), .comp_aux_valid(cpv),
        .comp_aux_below(below), .cal_range_fail(fail),
        .cal_alert_mask(cmask), .cell_high_voltage_alert(cell_al),
        .aux_hot_alert(aux_al), .aux_reference_select(refsel),
        .aux_pin_gpio_mode(gpio), .adc_offset_cal_alert(a_c),
        .ramp_offset_cal_alert(r_o), .ratio_offset_cal_alert(t_o),
        .pyramid_gain_cal_alert(p_g), .ramp_gain_cal_alert(r_g),
        .irq(irq));

    // 20 MHz clock
    always #25 hclk = ~hclk;

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [31:0] exp,
            input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // Waits for an edge with ready high; no wait length is assumed
    task automatic wait_rdy();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wait_rdy

    // One single word transfer; entered and left just after an edge
    task automatic bus(input logic wr, input logic [7:0] idx,
            input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] idx,
            input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(nm, exp, rd);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : rdchk

    // A measurement pulse lasts one cycle; the alert is seen next cycle
    task automatic cmeas(input logic [13:0] c, input logic u);
        cmv <= 1'b1;
        cuni <= u;
        cidx <= 4'h3;
        ccode <= c;
        tick(1);
        cmv <= 1'b0;
        tick(1);
    endtask : cmeas

    task automatic ameas(input logic [2:0] ch, input logic [13:0] c);
        amv <= 1'b1;
        achan <= ch;
        acode <= c;
        tick(1);
        amv <= 1'b0;
        tick(1);
    endtask : ameas

    task automatic t_reset();
        rdchk("aux_en_reset", IDX_AUX_HOT_EN, 32'h0000_0000);
        rdchk("force_reset", IDX_CAL_FORCE, 32'h0000_0000);
        rdchk("clr_reset", IDX_CELL_CLR, 32'h0000_fffc);
        check("cal_reset", 32'h0, {27'h0, calv});
    endtask : t_reset

    // Unused bits must read back zero; an unmapped place reads zero
    task automatic t_rw();
        wr(IDX_AUX_HOT_EN, 32'hffff_ffff);
        rdchk("aux_en_bits", IDX_AUX_HOT_EN, 32'h0000_003f);
        wr(IDX_AUX_HOT_EN, 32'h0000_0000);
        wr(IDX_CAL_FORCE, 32'hffff_ffe0);
        rdchk("force_bits", IDX_CAL_FORCE, 32'h0000_0000);
        wr(IDX_CELL_CLR, 32'hffff_0001);
        rdchk("clr_bits", IDX_CELL_CLR, 32'h0000_0000);
        wr(8'h25, 32'hffff_ffff);
        rdchk("unmapped", 8'h25, 32'h0000_0000);
    endtask : t_rw

    task automatic t_cal();
        for (int i = 0; i < 5; i++) begin
            wr(IDX_CAL_FORCE, 32'h1 << i);
            tick(3);
            check("cal_force", 32'h1 << i, {27'h0, calv});
        end
        tick(20);
        check("cal_hold", 32'h10, {27'h0, calv});
        cmask <= 5'h10;
        wr(IDX_CAL_FORCE, 32'h0000_0010);
        tick(3);
        check("cal_masked", 32'h0, {27'h0, calv});
        cmask <= 5'h00;
        tick(3);
        check("cal_unmask", 32'h10, {27'h0, calv});
        rdchk("irq_status", IDX_IRQ_STAT, 32'h0000_0004);
        // A set mask bit lets its status bit reach irq; new mask settles
        wr(IDX_IRQ_MASK, 32'h0000_0000);
        tick(1);
        check("irq_masked", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_MASK, 32'h0000_0007);
        tick(1);
        check("irq_mask", 32'h1, {31'h0, irq});
        wr(IDX_CAL_FORCE, 32'h0000_0000);
        fail <= 5'h02;
        tick(3);
        check("cal_data", 32'h02, {27'h0, calv});
        fail <= 5'h00;
        tick(3);
        check("cal_normal", 32'h0, {27'h0, calv});
        wr(IDX_IRQ_STAT, 32'h0000_0007);
        rdchk("irq_w1c", IDX_IRQ_STAT, 32'h0000_0000);
        check("irq_low", 32'h0, {31'h0, irq});
    endtask : t_cal

    // Set at 0x1000, clear at 0x0800; walk through both edges of the band
    task automatic t_cell();
        logic [13:0] cd [8] = '{14'h1001, 14'h0900, 14'h0000, 14'h0800,
            14'h0900, 14'h1000, 14'h1001, 14'h07ff};
        logic un [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        logic ex [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        wr(IDX_CELL_SET, 32'h0000_4000);
        wr(IDX_CELL_CLR, 32'h0000_2000);
        for (int i = 0; i < 8; i++) begin
            cmeas(cd[i], un[i]);
            check("cell_alert", {31'h0, ex[i]} << 3, {18'h0, cell_al});
        end
        wr(IDX_CELL_SET, 32'h0000_fffc);
        cmeas(14'h3fff, 1'b1);
        check("cell_off", 32'h0, {18'h0, cell_al});
    endtask : t_cell

    // Channel 3 uses the ratio level 0x200, the rest the absolute 0x100
    task automatic t_aux();
        wr(IDX_AUX_CFG, 32'h0000_0008);
        tick(1);
        check("refsel", 32'h08, {26'h0, refsel});
        wr(IDX_AUX_HOT_EN, 32'h0000_000c);
        ameas(3'd2, 14'h0180);
        ameas(3'd3, 14'h0180);
        check("aux_level", 32'h08, {26'h0, aux_al});
        ameas(3'd2, 14'h0080);
        check("aux_abs", 32'h0c, {26'h0, aux_al});
        wr(IDX_AUX_HOT_EN, 32'h0000_0008);
        tick(2);
        check("aux_clear", 32'h08, {26'h0, aux_al});
        wr(IDX_AUX_CFG, 32'h0000_0408);
        tick(1);
        check("gpio", 32'h04, {26'h0, gpio});
        wr(IDX_AUX_HOT_EN, 32'h0000_000c);
        ameas(3'd2, 14'h0080);
        check("aux_gpio", 32'h08, {26'h0, aux_al});
        rdchk("aux_en_gpio", IDX_AUX_HOT_EN, 32'h0000_000c);
        cpv <= 1'b1;
        below <= 6'h00;
        tick(1);
        below <= 6'h3f;
        tick(1);
        // First comparator pulse must have cleared channel 3
        check("aux_comp_low", 32'h00, {26'h0, aux_al});
        cpv <= 1'b0;
        tick(1);
        check("aux_comp", 32'h08, {26'h0, aux_al});
    endtask : t_aux

    // Reset held for twelve cycles, then the scenarios in turn
    initial begin
        tick(12);
        hresetn <= 1'b1;
        tick(1);
        t_reset();
        t_rw();
        t_cal();
        t_cell();
        t_aux();
        end_of_test();
    end
endmodule : acr_regs_tb_top
